// File: logic/light_pkg.sv
// shared constants and types for the dual-channel light readout
package light_pkg;
    localparam int CLK_PERIOD_NS = 5;
    localparam int DATA_W = 16;
    // integration periods in microseconds
    localparam int INTEG_SHORT_US = 13700;
    localparam int INTEG_MED_US = 101000;
    localparam int INTEG_LONG_US = 402000;
    localparam int INTEG_SHORT_CYC = INTEG_SHORT_US * 1000 / CLK_PERIOD_NS;
    localparam int INTEG_MED_CYC = INTEG_MED_US * 1000 / CLK_PERIOD_NS;
    localparam int INTEG_LONG_CYC = INTEG_LONG_US * 1000 / CLK_PERIOD_NS;
    // integration select codes
    localparam logic [1:0] INTEG_SEL_SHORT = 2'h0;
    localparam logic [1:0] INTEG_SEL_MED = 2'h1;
    localparam logic [1:0] INTEG_SEL_LONG = 2'h2;
    // full-scale counts per integration setting
    localparam logic [15:0] FULL_SHORT = 16'h13b7;
    localparam logic [15:0] FULL_MED = 16'h9139;
    localparam logic [15:0] FULL_LONG = 16'hffff;
    // address select pad codes
    localparam logic [1:0] ASEL_GND = 2'h0;
    localparam logic [1:0] ASEL_FLOAT = 2'h1;
    localparam logic [1:0] ASEL_VDD = 2'h2;
    // bus addresses, values arbitrary
    localparam logic [6:0] ADDR_GND = 7'h30;
    localparam logic [6:0] ADDR_FLOAT = 7'h31;
    localparam logic [6:0] ADDR_VDD = 7'h32;
    localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;
    // written data byte that releases a pending interrupt
    localparam logic [7:0] CMD_INT_CLEAR = 8'hc0;
    localparam logic [3:0] PERSIST_MAX = 4'hf;
    // serial slave states, gray along the write path
    typedef enum logic [2:0] {
        BUS_IDLE = 3'h0,
        BUS_ADDR = 3'h1,
        BUS_ACK = 3'h3,
        BUS_WR = 3'h2,
        BUS_RD = 3'h6,
        BUS_RDACK = 3'h7
    } bus_state_t;
endpackage : light_pkg

// File: logic/light_channel.sv
// one integrating channel: pulse counter with saturation
`timescale 1ns/100ps
`default_nettype none
module light_channel #(
    parameter int W = 16
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // control
    input wire logic restart,
    input wire logic [W-1:0] fullScale,
    // modulator
    input wire logic pulse,
    // result
    output logic [W-1:0] count
);
    logic [W-1:0] count_ff;

    // a pulse in the restart cycle opens the new period
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count_ff <= '0;
        end else if (restart) begin
            count_ff <= pulse ? W'(1) : '0;
        end else if (pulse && count_ff < fullScale) begin
            count_ff <= count_ff + W'(1);
        end
    end

    assign count = count_ff;
endmodule : light_channel
`default_nettype wire

// File: logic/window_check.sv
// threshold window compare of a finished result
`timescale 1ns/100ps
`default_nettype none
module window_check #(
    parameter int W = 16
) (
    // operands
    input wire logic [W-1:0] value,
    input wire logic [W-1:0] lowLimit,
    input wire logic [W-1:0] highLimit,
    // verdict
    output logic above,
    output logic below
);
    // strict compares: a value equal to a limit is still inside
    assign above = value > highLimit;
    assign below = value < lowLimit;
endmodule : window_check
`default_nettype wire

// File: logic/light_readout.sv
// dual-channel light converter: timing, results, interrupt, serial slave
`timescale 1ns/100ps
`default_nettype none
module light_readout #(
    parameter bit SMBUS_MODE = 1'b0,
    parameter int INTEG_SHORT_CYC = light_pkg::INTEG_SHORT_CYC,
    parameter int INTEG_MED_CYC = light_pkg::INTEG_MED_CYC,
    parameter int INTEG_LONG_CYC = light_pkg::INTEG_LONG_CYC
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // settings
    input wire logic powerUp,
    input wire logic gainHigh,
    input wire logic [1:0] integSel,
    input wire logic [15:0] lowThresh,
    input wire logic [15:0] highThresh,
    input wire logic [3:0] persistSel,
    input wire logic [1:0] addrSel,
    // analog front end
    input wire logic ch0Pulse,
    input wire logic ch1Pulse,
    output logic afeEnable,
    output logic afeGainHigh,
    // serial bus
    input wire logic scl,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    // interrupt pin
    output logic intOut,
    output logic intOe,
    // status
    output logic [15:0] ch0Data,
    output logic [15:0] ch1Data,
    output logic intPending
);
    logic [31:0] integCnt_ff;
    logic [31:0] integLen;
    logic [15:0] fullScale;
    logic convDone;
    logic restart;
    logic [15:0] cnt0;
    logic [15:0] cnt1;
    logic [15:0] ch0Data_ff;
    logic [15:0] ch1Data_ff;
    logic [15:0] snap0_ff;
    logic [15:0] snap1_ff;
    logic afeEnable_ff;
    logic afeGain_ff;
    logic above;
    logic below;
    logic outside;
    logic [3:0] persistCnt_ff;
    logic persistMet;
    logic intSet;
    logic intClr;
    logic intPending_ff;
    logic [6:0] ownAddr_ff;
    logic addrTaken_ff;
    logic sclQ_ff;
    logic sdaQ_ff;
    logic sclRise;
    logic sclFall;
    logic startDet;
    logic stopDet;
    light_pkg::bus_state_t state_ff;
    logic [2:0] bitCnt_ff;
    logic [7:0] rxShift_ff;
    logic [7:0] rxByte;
    logic [7:0] txShift_ff;
    logic [1:0] byteIdx_ff;
    logic isRead_ff;
    logic isAra_ff;
    logic ackSent_ff;
    logic masterNak_ff;
    logic sdaOe_ff;
    logic addrHit;
    logic araHit;
    logic snapLoad;
    logic wrClr;
    logic araClr;
    logic [7:0] curByte;
    logic [7:0] nextByte;

    // integration timing, one period shared by both channels
    always_comb begin
        case (integSel)
            light_pkg::INTEG_SEL_SHORT: begin
                integLen = 32'(INTEG_SHORT_CYC);
                fullScale = light_pkg::FULL_SHORT;
            end
            light_pkg::INTEG_SEL_MED: begin
                integLen = 32'(INTEG_MED_CYC);
                fullScale = light_pkg::FULL_MED;
            end
            default: begin
                integLen = 32'(INTEG_LONG_CYC);
                fullScale = light_pkg::FULL_LONG;
            end
        endcase
    end

    // a period is never shorter than one cycle, even with a tiny override
    assign convDone = powerUp && (integCnt_ff + 32'h1 >= integLen);
    assign restart = convDone || !powerUp;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            integCnt_ff <= '0;
        end else if (restart) begin
            integCnt_ff <= '0;
        end else begin
            integCnt_ff <= integCnt_ff + 32'h1;
        end
    end

    // settings handed to the analog side
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            afeEnable_ff <= 1'b0;
            afeGain_ff <= 1'b0;
        end else begin
            afeEnable_ff <= powerUp;
            afeGain_ff <= gainHigh;
        end
    end

    light_channel #(.W(light_pkg::DATA_W)) broadband (
        .clk(clk),
        .rstn(rstn),
        .restart(restart),
        .fullScale(fullScale),
        .pulse(ch0Pulse && powerUp),
        .count(cnt0)
    );

    light_channel #(.W(light_pkg::DATA_W)) infrared (
        .clk(clk),
        .rstn(rstn),
        .restart(restart),
        .fullScale(fullScale),
        .pulse(ch1Pulse && powerUp),
        .count(cnt1)
    );

    // both data registers load in the same cycle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ch0Data_ff <= '0;
            ch1Data_ff <= '0;
        end else if (convDone) begin
            ch0Data_ff <= cnt0;
            ch1Data_ff <= cnt1;
        end
    end

    // window and persistence on the broadband result
    window_check #(.W(light_pkg::DATA_W)) window (
        .value(cnt0),
        .lowLimit(lowThresh),
        .highLimit(highThresh),
        .above(above),
        .below(below)
    );

    assign outside = above || below;
    assign persistMet = ({1'b0, persistCnt_ff} + 5'h1) >= {1'b0, persistSel};
    assign intSet = convDone && outside && persistMet;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            persistCnt_ff <= '0;
        end else if (convDone) begin
            if (!outside) begin
                persistCnt_ff <= '0;
            end else if (persistCnt_ff != light_pkg::PERSIST_MAX) begin
                persistCnt_ff <= persistCnt_ff + 4'h1;
            end
        end
    end

    // sticky until cleared; a new event beats a clear in the same cycle
    assign intClr = wrClr || araClr;
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            intPending_ff <= 1'b0;
        end else if (intSet) begin
            intPending_ff <= 1'b1;
        end else if (intClr) begin
            intPending_ff <= 1'b0;
        end
    end

    // address pad caught once after reset release
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ownAddr_ff <= light_pkg::ADDR_FLOAT;
            addrTaken_ff <= 1'b0;
        end else if (!addrTaken_ff) begin
            addrTaken_ff <= 1'b1;
            case (addrSel)
                light_pkg::ASEL_GND: ownAddr_ff <= light_pkg::ADDR_GND;
                light_pkg::ASEL_VDD: ownAddr_ff <= light_pkg::ADDR_VDD;
                default: ownAddr_ff <= light_pkg::ADDR_FLOAT;
            endcase
        end
    end

    // bus line edges; pins arrive already synchronous
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclQ_ff <= 1'b1;
            sdaQ_ff <= 1'b1;
        end else begin
            sclQ_ff <= scl;
            sdaQ_ff <= sdaIn;
        end
    end

    assign sclRise = scl && !sclQ_ff;
    assign sclFall = !scl && sclQ_ff;
    assign startDet = scl && sclQ_ff && sdaQ_ff && !sdaIn;
    assign stopDet = scl && sclQ_ff && !sdaQ_ff && sdaIn;
    assign rxByte = {rxShift_ff[6:0], sdaIn};
    assign addrHit = rxByte[7:1] == ownAddr_ff;
    // alert response only answered while an alert is pending
    assign araHit = SMBUS_MODE && intPending_ff && rxByte[7:1] == light_pkg::ALERT_RESP_ADDR
        && rxByte[0];
    assign snapLoad = state_ff == light_pkg::BUS_ADDR && sclRise && bitCnt_ff == 3'h7
        && addrHit && rxByte[0];
    assign wrClr = state_ff == light_pkg::BUS_WR && sclRise && bitCnt_ff == 3'h7
        && rxByte == light_pkg::CMD_INT_CLEAR;
    assign araClr = state_ff == light_pkg::BUS_ACK && sclFall && ackSent_ff && isAra_ff;

    function automatic logic [7:0] pickByte(input logic [1:0] idx, input logic ara,
        input logic [6:0] addr, input logic [15:0] d0, input logic [15:0] d1);
        logic [7:0] b;
        b = 8'h00;
        if (ara) begin
            b = {addr, 1'b0};
        end else begin
            case (idx)
                2'h0: b = d0[7:0];
                2'h1: b = d0[15:8];
                2'h2: b = d1[7:0];
                default: b = d1[15:8];
            endcase
        end
        return b;
    endfunction : pickByte

    // byte at the current and at the next index, from the snapshot, or the own address for an alert response
    assign curByte = pickByte(byteIdx_ff, isAra_ff, ownAddr_ff, snap0_ff, snap1_ff);
    assign nextByte = pickByte(byteIdx_ff + 2'h1, isAra_ff, ownAddr_ff, snap0_ff, snap1_ff);

    // read snapshot taken at address match, held for the whole read
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            snap0_ff <= '0;
            snap1_ff <= '0;
        end else if (snapLoad) begin
            snap0_ff <= ch0Data_ff;
            snap1_ff <= ch1Data_ff;
        end
    end

    // serial slave; only ack and read data ever pull the line
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_ff <= light_pkg::BUS_IDLE;
            bitCnt_ff <= '0;
            rxShift_ff <= '0;
            txShift_ff <= '0;
            byteIdx_ff <= '0;
            isRead_ff <= 1'b0;
            isAra_ff <= 1'b0;
            ackSent_ff <= 1'b0;
            masterNak_ff <= 1'b0;
            sdaOe_ff <= 1'b0;
        end else if (startDet) begin
            state_ff <= light_pkg::BUS_ADDR;
            bitCnt_ff <= '0;
            sdaOe_ff <= 1'b0;
        end else if (stopDet) begin
            state_ff <= light_pkg::BUS_IDLE;
            sdaOe_ff <= 1'b0;
        end else begin
            case (state_ff)
                light_pkg::BUS_ADDR: begin
                    if (sclRise) begin
                        rxShift_ff <= rxByte;
                        bitCnt_ff <= bitCnt_ff + 3'h1;
                        if (bitCnt_ff == 3'h7) begin
                            state_ff <= (addrHit || araHit) ? light_pkg::BUS_ACK : light_pkg::BUS_IDLE;
                            isRead_ff <= rxByte[0];
                            isAra_ff <= araHit && !addrHit;
                            byteIdx_ff <= '0;
                            ackSent_ff <= 1'b0;
                        end
                    end
                end
                light_pkg::BUS_ACK: begin
                    if (sclFall) begin
                        if (!ackSent_ff) begin
                            sdaOe_ff <= 1'b1;
                            ackSent_ff <= 1'b1;
                        end else begin
                            ackSent_ff <= 1'b0;
                            bitCnt_ff <= '0;
                            if (isRead_ff) begin
                                state_ff <= light_pkg::BUS_RD;
                                txShift_ff <= curByte;
                                sdaOe_ff <= !curByte[7];
                            end else begin
                                state_ff <= light_pkg::BUS_WR;
                                sdaOe_ff <= 1'b0;
                            end
                        end
                    end
                end
                light_pkg::BUS_WR: begin
                    if (sclRise) begin
                        rxShift_ff <= rxByte;
                        bitCnt_ff <= bitCnt_ff + 3'h1;
                        if (bitCnt_ff == 3'h7) begin
                            state_ff <= light_pkg::BUS_ACK;
                            ackSent_ff <= 1'b0;
                        end
                    end
                end
                light_pkg::BUS_RD: begin
                    if (sclFall) begin
                        if (bitCnt_ff == 3'h7) begin
                            sdaOe_ff <= 1'b0;
                            state_ff <= light_pkg::BUS_RDACK;
                        end else begin
                            txShift_ff <= {txShift_ff[6:0], 1'b0};
                            sdaOe_ff <= !txShift_ff[6];
                            bitCnt_ff <= bitCnt_ff + 3'h1;
                        end
                    end
                end
                light_pkg::BUS_RDACK: begin
                    if (sclRise) begin
                        masterNak_ff <= sdaIn;
                    end else if (sclFall) begin
                        if (masterNak_ff) begin
                            state_ff <= light_pkg::BUS_IDLE;
                        end else begin
                            state_ff <= light_pkg::BUS_RD;
                            byteIdx_ff <= byteIdx_ff + 2'h1;
                            bitCnt_ff <= '0;
                            txShift_ff <= nextByte;
                            sdaOe_ff <= !nextByte[7];
                        end
                    end
                end
                default: begin
                    sdaOe_ff <= 1'b0;
                end
            endcase
        end
    end

    // open-drain pins: data is always low, only the enable moves
    assign sdaOut = 1'b0;
    assign sdaOe = sdaOe_ff;
    assign intOut = 1'b0;
    assign intOe = intPending_ff;
    assign afeEnable = afeEnable_ff;
    assign afeGainHigh = afeGain_ff;
    assign ch0Data = ch0Data_ff;
    assign ch1Data = ch1Data_ff;
    assign intPending = intPending_ff;

    same_restart_a: assert property (@(posedge clk) disable iff (!rstn)
        restart |=> cnt0 <= 16'h1 && cnt1 <= 16'h1) else $error("channels not restarted together");
    data_load_a: assert property (@(posedge clk) disable iff (!rstn)
        convDone |=> ch0Data_ff == $past(cnt0) && ch1Data_ff == $past(cnt1)) else $error("result not loaded");
    snap_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        state_ff == light_pkg::BUS_RD && !snapLoad |=> $stable(snap0_ff) && $stable(snap1_ff))
        else $error("read snapshot changed mid read");
    auto_restart_a: assert property (@(posedge clk) disable iff (!rstn)
        convDone |=> integCnt_ff == 32'h0 ##1 (integCnt_ff == 32'h1 || !powerUp || convDone))
        else $error("next period did not start");
    saturate_count_a: assert property (@(posedge clk) disable iff (!rstn)
        !restart && !$past(restart) && $stable(integSel) |-> cnt0 <= fullScale && cnt1 <= fullScale)
        else $error("count above full scale");
    int_raise_a: assert property (@(posedge clk) disable iff (!rstn)
        intSet |=> intPending_ff && intOe) else $error("interrupt not raised");
    int_persist_a: assert property (@(posedge clk) disable iff (!rstn)
        $rose(intPending_ff) |-> $past(convDone) && $past(outside) && $past(persistMet))
        else $error("interrupt without cause");
    int_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        intPending_ff && !intSet && !intClr |=> intPending_ff) else $error("interrupt dropped without clear");
    power_down_a: assert property (@(posedge clk) disable iff (!rstn)
        !powerUp ##1 !powerUp |-> integCnt_ff == 32'h0 && !afeEnable && !convDone)
        else $error("conversion active in power down");
    sda_drive_a: assert property (@(posedge clk) disable iff (!rstn)
        sdaOe_ff |-> state_ff == light_pkg::BUS_ACK || state_ff == light_pkg::BUS_RD)
        else $error("data line driven outside ack or read");
endmodule : light_readout
`default_nettype wire

// File: tb/host_model.sv
// two-wire bus host model driving the serial clock and pulling data low
`timescale 1ns/100ps
`default_nettype none
module host_model (
    // clock
    input wire logic clk,
    // serial bus
    input wire logic sdaLine,
    output logic scl,
    output logic hostPull
);
    // quarter of a 400 kHz bit in 5 ns cycles
    localparam int Q = 125;
    initial begin
        scl = 1'b1;
        hostPull = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask : wait_clk
    // host owns the clock; device only receives it
    task automatic send_start();
        hostPull <= 1'b1;
        wait_clk(Q);
        scl <= 1'b0;
        wait_clk(Q);
    endtask : send_start
    task automatic send_stop();
        hostPull <= 1'b1;
        wait_clk(Q);
        scl <= 1'b1;
        wait_clk(Q);
        hostPull <= 1'b0;
        wait_clk(Q);
    endtask : send_stop
    // data changes only while the clock is low, sampled mid high phase
    task automatic bit_cycle(input logic b, output logic s);
        hostPull <= ~b;
        wait_clk(Q);
        scl <= 1'b1;
        wait_clk(Q);
        s = sdaLine;
        wait_clk(Q);
        scl <= 1'b0;
        wait_clk(Q);
    endtask : bit_cycle
    // ackIn 1 leaves the line released (nack), ackOut 1 means line seen low
    task automatic xfer_byte(input logic [7:0] tx, input logic ackIn, output logic [7:0] rx, output logic ackOut);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_cycle(tx[i], rx[i]);
        end
        bit_cycle(ackIn, s);
        ackOut = ~s;
    endtask : xfer_byte
endmodule : host_model
`default_nettype wire

// File: tb/dual_channel_light_sensor_readout_test.sv
// self-checking bench for the dual-channel light readout
`timescale 1ns/100ps
`default_nettype none
module dual_channel_light_sensor_readout_test;
    localparam int SHORT_L = 6000;
    localparam int MED_L = 100;
    localparam int LONG_L = 200;
    logic clk, rstn, powerUp, gainHigh, ch0Pulse, ch1Pulse, hostPull;
    logic [1:0] integSel, addrSel;
    logic [15:0] lowThresh, highThresh, ch0Data, ch1Data;
    logic [3:0] persistSel;
    logic afeEnable, afeGainHigh, scl, sdaOut, sdaOe, intOut, intOe, intPending, ack;
    logic alertOe, alertPending;
    logic [7:0] rx;
    logic [15:0] expRd [4] = '{16'h0064, 16'h0000, 16'h0032, 16'h0000};
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;
    // pulled-up data line: low when anyone pulls
    wire logic sdaLine = ~(hostPull | sdaOe | alertOe);
    light_readout #(.SMBUS_MODE(1'b0), .INTEG_SHORT_CYC(SHORT_L), .INTEG_MED_CYC(MED_L),
        .INTEG_LONG_CYC(LONG_L)) u_dut (.clk(clk), .rstn(rstn), .powerUp(powerUp), .gainHigh(gainHigh),
        .integSel(integSel), .lowThresh(lowThresh), .highThresh(highThresh), .persistSel(persistSel),
        .addrSel(addrSel), .ch0Pulse(ch0Pulse), .ch1Pulse(ch1Pulse), .afeEnable(afeEnable),
        .afeGainHigh(afeGainHigh), .scl(scl), .sdaIn(sdaLine), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .intOut(intOut), .intOe(intOe), .ch0Data(ch0Data), .ch1Data(ch1Data), .intPending(intPending));
    // second device in alert mode on the same bus, vdd address
    light_readout #(.SMBUS_MODE(1'b1), .INTEG_SHORT_CYC(SHORT_L), .INTEG_MED_CYC(MED_L),
        .INTEG_LONG_CYC(LONG_L)) u_alert (.clk(clk), .rstn(rstn), .powerUp(powerUp), .gainHigh(gainHigh),
        .integSel(integSel), .lowThresh(lowThresh), .highThresh(highThresh), .persistSel(persistSel),
        .addrSel(light_pkg::ASEL_VDD), .ch0Pulse(ch0Pulse), .ch1Pulse(ch1Pulse), .afeEnable(),
        .afeGainHigh(), .scl(scl), .sdaIn(sdaLine), .sdaOut(), .sdaOe(alertOe),
        .intOut(), .intOe(), .ch0Data(), .ch1Data(), .intPending(alertPending));
    host_model u_host (.clk(clk), .sdaLine(sdaLine), .scl(scl), .hostPull(hostPull));
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // infrared sees half the pulses so the two channels differ
    always @(posedge clk) ch1Pulse <= ~ch1Pulse;
    task automatic test_done();
        $display("checks %0d, miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : test_done
    // whole run needs about 61k cycles
    always @(posedge clk) begin
        cycles = cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            $display("Error at %0t: run timed out", $time);
            test_done();
        end
    end
    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk16
    task automatic chk1(input logic got, input logic exp);
        chk16({15'h0000, got}, {15'h0000, exp});
    endtask : chk1
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    task automatic wait_first_result();
        for (int k = 0; k < 3 * MED_L && ch0Data === 16'h0000; k++) tick(1);
    endtask : wait_first_result
    initial begin
        rstn = 1'b0;
        powerUp = 1'b1;
        gainHigh = 1'b0;
        integSel = light_pkg::INTEG_SEL_MED;
        lowThresh = 16'h0000;
        highThresh = 16'hffff;
        persistSel = 4'h0;
        addrSel = light_pkg::ASEL_GND;
        ch0Pulse = 1'b1;
        ch1Pulse = 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        tick(2);
        chk1(afeEnable, 1'b1);
        wait_first_result();
        tick(MED_L);
        chk16(ch0Data, 16'h0064);
        chk16(ch1Data, 16'h0032);
        chk1(intOe, 1'b0);
        chk1(intOut, 1'b0);
        chk1(sdaOut, 1'b0);
        @(posedge clk) gainHigh <= 1'b1;
        tick(2);
        chk1(afeGainHigh, 1'b1);
        u_host.send_start();
        u_host.xfer_byte({light_pkg::ADDR_GND, 1'b1}, 1'b1, rx, ack);
        chk1(ack, 1'b1);
        for (int i = 0; i < 4; i++) begin
            u_host.xfer_byte(8'hff, i == 3, rx, ack);
            chk16({8'h00, rx}, expRd[i]);
        end
        u_host.send_stop();
        u_host.send_start();
        u_host.xfer_byte({7'h33, 1'b0}, 1'b1, rx, ack);
        chk1(ack, 1'b0);
        u_host.send_stop();
        @(posedge clk) begin
            highThresh <= 16'h0063;
            persistSel <= 4'h3;
        end
        tick(2 * MED_L - 5);
        chk1(intOe, 1'b0);
        for (int k = 0; k < MED_L + 10 && intOe !== 1'b1; k++) tick(1);
        chk1(intOe, 1'b1);
        @(posedge clk) highThresh <= 16'hffff;
        tick(3 * MED_L);
        chk1(intOe, 1'b1);
        chk1(intPending, 1'b1);
        chk1(alertPending, 1'b1);
        u_host.send_start();
        u_host.xfer_byte({light_pkg::ALERT_RESP_ADDR, 1'b1}, 1'b1, rx, ack);
        chk1(ack, 1'b1);
        u_host.xfer_byte(8'hff, 1'b1, rx, ack);
        chk16({8'h00, rx}, {8'h00, light_pkg::ADDR_VDD, 1'b0});
        u_host.send_stop();
        chk1(alertPending, 1'b0);
        chk1(intPending, 1'b1);
        u_host.send_start();
        u_host.xfer_byte({light_pkg::ADDR_GND, 1'b0}, 1'b1, rx, ack);
        u_host.xfer_byte(light_pkg::CMD_INT_CLEAR, 1'b1, rx, ack);
        u_host.send_stop();
        chk1(intOe, 1'b0);
        @(posedge clk) powerUp <= 1'b0;
        tick(2);
        chk1(afeEnable, 1'b0);
        tick(2 * MED_L);
        chk16(ch0Data, 16'h0064);
        @(posedge clk) begin
            integSel <= light_pkg::INTEG_SEL_SHORT;
            powerUp <= 1'b1;
        end
        tick(2 * SHORT_L + 10);
        chk16(ch0Data, light_pkg::FULL_SHORT);
        chk16(ch1Data, 16'h0bb8);
        @(posedge clk) integSel <= light_pkg::INTEG_SEL_LONG;
        tick(2 * LONG_L + 10);
        chk16(ch0Data, 16'h00c8);
        chk16(ch1Data, 16'h0064);
        test_done();
    end
endmodule : dual_channel_light_sensor_readout_test
`default_nettype wire
